// File: act_defines.svh
// Purpose: constants of the conversion timing block
// Assumes: 200 MHz cpu clock, apb byte addresses
// Notes: definitions only
`ifndef ACT_DEFINES_SVH
`define ACT_DEFINES_SVH
`define ACT_OFF_CTRL 8'h00
`define ACT_OFF_RESULT 8'h04
`define ACT_OFF_STATUS 8'h08
`define ACT_OFF_MASK 8'h0c
`define ACT_DIV_HI 15
`define ACT_DIV_LO 14
`define ACT_SMP_HI 13
`define ACT_SMP_LO 12
`define ACT_START_BIT 0
`define ACT_CTRL_WMASK 16'hf000
`define ACT_CTRL_RST 16'h0000
`define ACT_BUSY_BIT 8
`define ACT_ST_DONE 0
`define ACT_ST_SAT 1
`define ACT_DIV_00 5'h04
`define ACT_DIV_01 5'h02
`define ACT_DIV_10 5'h10
`define ACT_DIV_11 5'h08
`define ACT_SMP_00 7'h08
`define ACT_SMP_01 7'h10
`define ACT_SMP_10 7'h20
`define ACT_SMP_11 7'h40
`define ACT_CONV_STEPS 6'h28
`define ACT_LOAD_CYC 6'h02
`define ACT_RES_MAX 10'h3ff
`endif

// File: act_pkg.sv
// Purpose: types of the conversion timing block
// Assumes: nothing
// Notes: register state is one packed struct
package act_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV = 2'b10,
    ST_LOAD = 2'b11
  } act_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } act_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } act_apb_rsp_t;
  typedef struct packed {
    act_state_t st;
    logic [3:0] pre;
    logic [5:0] cnt;
    logic [3:0] ctl;
    logic [1:0] div_sel;
    logic [1:0] smp_sel;
    logic [9:0] held;
    logic below;
    logic above;
    logic [9:0] sar;
    logic [9:0] bitm;
    logic [9:0] res;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic busy;
    logic samp;
    logic fin;
    act_apb_rsp_t rsp;
  } act_regs_t;
endpackage

// File: act_conv_timing.sv
// Purpose: sar converter timing, result saturation and apb registers
// Assumes: digitised input code and range flags arrive synchronous
// Notes: one wait state on every apb access
//
// Functional notes
// - basic clock is cpu clock divided 4/2/16/8
// - sample period 8/16/32/64 basic clocks
// - conversion: sample, 40 basic clocks, 2 cpu
// - conversion duration set by divider and sample codes only, not by the input
// - out-of-range input gives 000 or 3ff
// - input frozen at end of sample
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`include "act_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module act_conv_timing #(
  parameter int RES_W = 10
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire act_pkg::act_apb_req_t apb_i,
  output act_pkg::act_apb_rsp_t apb_o,
  input wire logic [9:0] ain_code_i,
  input wire logic ain_below_i,
  input wire logic ain_above_i,
  output logic sample_en_o,
  output logic busy_o,
  output logic irq_o
);
  generate
    if (RES_W != 10) begin : g_bad_width
      $error("act_conv_timing serves a 10-bit result only");
    end
  endgenerate

  act_pkg::act_regs_t q_r;
  act_pkg::act_regs_t q_nxt;

  function automatic logic [4:0] div_of(input logic [1:0] s);
    case (s)
      2'b00: div_of = `ACT_DIV_00;
      2'b01: div_of = `ACT_DIV_01;
      2'b10: div_of = `ACT_DIV_10;
      default: div_of = `ACT_DIV_11;
    endcase
  endfunction

  function automatic logic [6:0] smp_of(input logic [1:0] s);
    case (s)
      2'b00: smp_of = `ACT_SMP_00;
      2'b01: smp_of = `ACT_SMP_01;
      2'b10: smp_of = `ACT_SMP_10;
      default: smp_of = `ACT_SMP_11;
    endcase
  endfunction

  logic tick;
  logic acc;
  logic wr_en;
  logic start;
  logic [1:0] w1c;
  logic [1:0] set_ev;
  logic [9:0] trial;

  // basic clock tick, prescaler restarted at each start
  assign tick = ({1'b0, q_r.pre} == div_of(q_r.div_sel) - 5'h01);
  assign acc = apb_i.psel && apb_i.penable;
  assign wr_en = acc && q_r.rsp.pready && apb_i.pwrite;
  assign trial = q_r.sar | q_r.bitm;

  always_comb begin
    q_nxt = q_r;
    start = 1'b0;
    w1c = 2'b00;
    set_ev = 2'b00;
    q_nxt.fin = 1'b0;
    q_nxt.pre = tick ? 4'h0 : q_r.pre + 4'h1;
    // register writes take effect at the completing edge only
    if (wr_en) begin
      case (apb_i.paddr)
        `ACT_OFF_CTRL: begin
          // field changes during a conversion wait for the next start
          q_nxt.ctl = apb_i.pwdata[`ACT_DIV_HI:`ACT_SMP_LO];
          start = apb_i.pwdata[`ACT_START_BIT] && (q_r.st == act_pkg::ST_IDLE);
        end
        `ACT_OFF_STATUS: w1c = apb_i.pwdata[1:0];
        `ACT_OFF_MASK: q_nxt.mask = apb_i.pwdata[1:0];
        default: ;
      endcase
    end
    case (q_r.st)
      act_pkg::ST_IDLE: begin
        if (start) begin
          // selects latched so the running conversion keeps its length
          q_nxt.div_sel = q_nxt.ctl[3:2];
          q_nxt.smp_sel = q_nxt.ctl[1:0];
          q_nxt.pre = 4'h0;
          q_nxt.cnt = 6'h00;
          q_nxt.st = act_pkg::ST_SAMPLE;
        end
      end
      act_pkg::ST_SAMPLE: begin
        if (tick) begin
          q_nxt.cnt = q_r.cnt + 6'h01;
          if ({1'b0, q_r.cnt} == smp_of(q_r.smp_sel) - 7'h01) begin
            q_nxt.held = ain_code_i;
            q_nxt.below = ain_below_i;
            q_nxt.above = ain_above_i && !ain_below_i;
            q_nxt.sar = 10'h000;
            q_nxt.bitm = 10'h200;
            q_nxt.cnt = 6'h00;
            q_nxt.st = act_pkg::ST_CONV;
          end
        end
      end
      act_pkg::ST_CONV: begin
        if (tick) begin
          q_nxt.cnt = q_r.cnt + 6'h01;
          // four basic clocks per bit decision
          if (q_r.cnt[1:0] == 2'b11) begin
            if (trial <= q_r.held) begin
              q_nxt.sar = trial;
            end
            q_nxt.bitm = q_r.bitm >> 1;
          end
          if (q_r.cnt == `ACT_CONV_STEPS - 6'h01) begin
            q_nxt.cnt = 6'h00;
            q_nxt.st = act_pkg::ST_LOAD;
          end
        end
      end
      act_pkg::ST_LOAD: begin
        q_nxt.cnt = q_r.cnt + 6'h01;
        if (q_r.cnt == `ACT_LOAD_CYC - 6'h01) begin
          if (q_r.below) begin
            q_nxt.res = 10'h000;
          end else if (q_r.above) begin
            q_nxt.res = `ACT_RES_MAX;
          end else begin
            q_nxt.res = q_r.sar;
          end
          set_ev[`ACT_ST_DONE] = 1'b1;
          set_ev[`ACT_ST_SAT] = q_r.below || q_r.above;
          q_nxt.fin = 1'b1;
          q_nxt.cnt = 6'h00;
          q_nxt.st = act_pkg::ST_IDLE;
        end
      end
      default: q_nxt.st = act_pkg::ST_IDLE;
    endcase
    // hardware set beats a same-cycle software clear
    q_nxt.stat = (q_r.stat & ~w1c) | set_ev;
    q_nxt.irq = |(q_nxt.stat & q_nxt.mask);
    q_nxt.busy = (q_nxt.st != act_pkg::ST_IDLE);
    q_nxt.samp = (q_nxt.st == act_pkg::ST_SAMPLE);
    // apb: answer one cycle into the access phase
    q_nxt.rsp.pready = acc && !q_r.rsp.pready;
    q_nxt.rsp.pslverr = 1'b0;
    q_nxt.rsp.prdata = 32'h0000_0000;
    if (acc && !q_r.rsp.pready) begin
      case (apb_i.paddr)
        `ACT_OFF_CTRL: q_nxt.rsp.prdata[`ACT_DIV_HI:`ACT_SMP_LO] = q_r.ctl;
        `ACT_OFF_RESULT: q_nxt.rsp.prdata[9:0] = q_r.res;
        `ACT_OFF_STATUS: begin
          q_nxt.rsp.prdata[1:0] = q_r.stat;
          q_nxt.rsp.prdata[`ACT_BUSY_BIT] = q_r.busy;
        end
        `ACT_OFF_MASK: q_nxt.rsp.prdata[1:0] = q_r.mask;
        default: q_nxt.rsp.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q_r <= '0;
      q_r.ctl <= 4'(`ACT_CTRL_RST >> `ACT_SMP_LO);
    end else begin
      q_r <= q_nxt;
    end
  end

  assign apb_o = q_r.rsp;
  assign sample_en_o = q_r.samp;
  assign busy_o = q_r.busy;
  assign irq_o = q_r.irq;

  // helper counters read only by the checks below
  logic [11:0] dur_r;
  logic [4:0] gap_r;
  logic [11:0] exp_len;
  logic [11:0] smp_len;
  // widened before the product so the longest setting cannot wrap
  assign smp_len = 12'(div_of(q_r.div_sel)) * 12'(smp_of(q_r.smp_sel));
  assign exp_len = 12'(div_of(q_r.div_sel)) * (12'(smp_of(q_r.smp_sel)) + 12'(`ACT_CONV_STEPS))
    + 12'(`ACT_LOAD_CYC);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dur_r <= 12'h000;
      gap_r <= 5'h00;
    end else begin
      dur_r <= q_r.busy ? dur_r + 12'h001 : 12'h000;
      gap_r <= (tick || !q_r.busy) ? 5'h00 : gap_r + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_tick_gap;
    (tick && q_r.busy && q_r.st != act_pkg::ST_LOAD) |-> (gap_r + 5'h01 == div_of(q_r.div_sel));
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("basic clock period wrong");
  property p_sample_len;
    (q_r.st == act_pkg::ST_SAMPLE && q_nxt.st == act_pkg::ST_CONV) |-> (dur_r + 12'h001 == smp_len);
  endproperty
  a_sample_len: assert property (p_sample_len) else $error("sample period wrong");
  property p_conv_len;
    q_r.fin |-> (dur_r == exp_len) && !q_r.busy;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion time wrong");
  property p_sel_stable;
    (q_r.busy && q_nxt.busy) |=> $stable(q_r.div_sel) && $stable(q_r.smp_sel);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("timing changed mid conversion");
  property p_sat_low;
    (q_r.fin && q_r.below) |-> (q_r.res == 10'h000) && q_r.stat[`ACT_ST_SAT];
  endproperty
  a_sat_low: assert property (p_sat_low) else $error("low input not zero");
  property p_sat_high;
    (q_r.fin && q_r.above) |-> (q_r.res == `ACT_RES_MAX);
  endproperty
  a_sat_high: assert property (p_sat_high) else $error("high input not full scale");
  property p_frozen;
    (q_r.st == act_pkg::ST_CONV) |=> $stable(q_r.held) [*2];
  endproperty
  a_frozen: assert property (p_frozen) else $error("held input changed");
  property p_done_with_load;
    (q_r.st == act_pkg::ST_LOAD && q_r.cnt == 6'h01) |=> q_r.stat[`ACT_ST_DONE] && q_r.fin;
  endproperty
  a_done_with_load: assert property (p_done_with_load) else $error("done not with load");

  // phase boundaries, pulse shapes and result values
  property p_start_busy;
    start |=> q_r.busy && q_r.samp && q_r.pre == 4'h0;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken");

  property p_samp_in_busy;
    q_r.samp |-> q_r.busy && q_r.st == act_pkg::ST_SAMPLE;
  endproperty
  a_samp_in_busy: assert property (p_samp_in_busy) else $error("sampling outside busy");

  property p_gap_bound;
    q_r.busy |-> gap_r < div_of(q_r.div_sel);
  endproperty
  a_gap_bound: assert property (p_gap_bound) else $error("basic clock tick missing");

  property p_conv_steps;
    (q_r.st == act_pkg::ST_CONV && q_nxt.st == act_pkg::ST_LOAD)
      |-> (dur_r + 12'h001 == exp_len - 12'(`ACT_LOAD_CYC));
  endproperty
  a_conv_steps: assert property (p_conv_steps) else $error("step phase wrong");

  property p_load_len;
    (q_r.st == act_pkg::ST_CONV && q_nxt.st == act_pkg::ST_LOAD)
      |=> (q_r.st == act_pkg::ST_LOAD) ##1 (q_r.st == act_pkg::ST_LOAD) ##1 q_r.fin;
  endproperty
  a_load_len: assert property (p_load_len) else $error("result load not two cycles");

  property p_freeze_edge;
    (q_r.st == act_pkg::ST_SAMPLE && q_nxt.st == act_pkg::ST_CONV)
      |=> (q_r.held == $past(ain_code_i));
  endproperty
  a_freeze_edge: assert property (p_freeze_edge) else $error("input not frozen at edge");

  property p_result_held;
    (q_r.fin && !q_r.below && !q_r.above) |-> (q_r.res == q_r.held);
  endproperty
  a_result_held: assert property (p_result_held) else $error("result not held code");

  property p_sat_status;
    (q_r.fin && (q_r.below || q_r.above)) |-> q_r.stat[`ACT_ST_SAT];
  endproperty
  a_sat_status: assert property (p_sat_status) else $error("saturation not flagged");

  property p_res_kept;
    !q_r.fin |-> $stable(q_r.res);
  endproperty
  a_res_kept: assert property (p_res_kept) else $error("result moved without a load");

  property p_done_pulse;
    q_r.fin |=> !q_r.fin;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("completion pulse too long");

  c_fast_conv: cover property (q_r.fin && q_r.div_sel == 2'b01 && q_r.smp_sel == 2'b00);
  c_saturated: cover property (q_r.fin && q_r.above);
  c_set_clear: cover property (set_ev[`ACT_ST_DONE] && w1c[`ACT_ST_DONE]);
  c_restart_ignored: cover property (wr_en && apb_i.paddr == `ACT_OFF_CTRL
    && apb_i.pwdata[`ACT_START_BIT] && q_r.busy);
  c_irq_rise: cover property (!q_r.irq && q_nxt.irq);
endmodule
`default_nettype wire

// File: adc_conversion_timing_tb.sv
// Purpose: self-checking bench for the conversion timing block
// Assumes: one wait state apb slave, map at 0x00/0x04/0x08/0x0c
// Notes: input code changes right around the freeze edge to catch early or late sampling
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_timing_tb;
  logic clk_i;
  logic reset_n_i;
  act_pkg::act_apb_req_t req;
  act_pkg::act_apb_rsp_t rsp;
  logic [9:0] ain_code_i;
  logic ain_below_i;
  logic ain_above_i;
  logic sample_en_o;
  logic busy_o;
  logic irq_o;
  int n_fail;
  int total_checks;
  logic [31:0] q;
  logic e;

  act_conv_timing DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .apb_i(req), .apb_o(rsp),
    .ain_code_i(ain_code_i), .ain_below_i(ain_below_i), .ain_above_i(ain_above_i),
    .sample_en_o(sample_en_o), .busy_o(busy_o), .irq_o(irq_o));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // the request stands until pready is sampled, then is released at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    if (k >= 50) chk("pready", 32'h0, 32'h1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic test_reset;
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("ctrl", q, 32'h0);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("status", q, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk("mask", q, 32'h0);
    chk("outs", {busy_o, sample_en_o, irq_o}, 32'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk("unmapped err", e, 32'h1);
    chk("unmapped data", q, 32'h0);
    $display("test reset done");
  endtask

  task automatic conv(input logic [1:0] ds, input logic [1:0] ss, input logic lo, input logic hi);
    int dv;
    int sm;
    int n;
    int se;
    logic [9:0] v;
    dv = (ds == 2'b00) ? 4 : (ds == 2'b01) ? 2 : (ds == 2'b10) ? 16 : 8;
    sm = 8 << ss;
    v = {ds, ss, 6'h2a};
    ain_below_i <= lo;
    ain_above_i <= hi;
    ain_code_i <= ~v;
    apb(1'b1, 8'h08, 32'h3, q, e);
    apb(1'b1, 8'h00, {16'h0, ds, ss, 12'h001}, q, e);
    n = 0;
    #1;
    se = sample_en_o;
    while (busy_o === 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
      if (n == dv * sm - 1) ain_code_i <= v;
      if (n == dv * sm) ain_code_i <= ~v;
      #1;
      if (sample_en_o === 1'b1) se++;
    end
    chk("conv time", n, dv * (sm + 40) + 2);
    chk("sample len", se, dv * sm);
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk("result", q, lo ? 32'h0 : hi ? 32'h3ff : {22'h0, v});
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("status", q, {30'h0, lo | hi, 1'b1});
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("ctrl", q, {16'h0, ds, ss, 12'h000});
  endtask

  task automatic test_irq;
    chk("irq masked", irq_o, 32'h0);
    apb(1'b1, 8'h0c, 32'h1, q, e);
    @(posedge clk_i);
    #1;
    chk("irq on", irq_o, 32'h1);
    apb(1'b1, 8'h08, 32'h1, q, e);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("done cleared", q, 32'h2);
    chk("irq off", irq_o, 32'h0);
    apb(1'b1, 8'h0c, 32'h2, q, e);
    @(posedge clk_i);
    #1;
    chk("irq sat", irq_o, 32'h1);
    apb(1'b1, 8'h08, 32'h2, q, e);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("sat cleared", q, 32'h0);
    chk("irq sat off", irq_o, 32'h0);
    $display("test irq done");
  endtask

  // a start or new fields while busy must leave the running conversion alone
  task automatic test_busy;
    realtime t0;
    int n;
    n = 0;
    apb(1'b1, 8'h00, 32'h0000_4001, q, e);
    t0 = $realtime;
    apb(1'b1, 8'h00, 32'h0000_3001, q, e);
    while (busy_o === 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
      #1;
    end
    chk("busy restart", int'(($realtime - t0 - 1.0) / 5.0), 2 * (8 + 40) + 2);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("fields kept", q, 32'h0000_3000);
    // reset in mid conversion
    apb(1'b1, 8'h00, 32'h0000_4001, q, e);
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    chk("reset outs", {busy_o, sample_en_o, irq_o}, 32'h0);
    apb(1'b0, 8'h00, 32'h0, q, e);
    chk("reset ctrl", q, 32'h0);
    apb(1'b0, 8'h08, 32'h0, q, e);
    chk("reset status", q, 32'h0);
    $display("test busy done");
  endtask

  initial begin
    req = '0;
    reset_n_i = 1'b0;
    ain_code_i = 10'h000;
    ain_below_i = 1'b0;
    ain_above_i = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    test_reset();
    // every divider and sample code once, in-range input; cycle counts, sample length, result, status and ctrl checked
    for (int i = 0; i < 16; i++) conv(i[3:2], i[1:0], 1'b0, 1'b0);
    $display("test timing done");
    conv(2'b01, 2'b00, 1'b1, 1'b0);
    conv(2'b01, 2'b00, 1'b0, 1'b1);
    // both flags: below wins
    conv(2'b01, 2'b00, 1'b1, 1'b1);
    $display("test saturation done");
    test_irq();
    test_busy();
    report_and_stop();
  end

  // whole run is about 10k cycles; six times that means a hang
  initial begin
    #300000;
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
